// *** logic/adc_window_comparator.sv ***
// Summary of operation
// - Compare every finished conversion automatically; code drops any inside the minimum conversion time
// - Window hit sets match flag, interrupt or poll
// - Two 16-bit limits from high/low byte pairs
// - Limit order selects inside or outside window
// - Single-ended: unsigned 16-bit compare
// - Less above greater: flag strictly between
// - Outside window: strict compare, bounds not flagged
// - Differential: signed two's complement compare
// - Signed inside window strictly between limits
// - Signed outside window strictly beyond limits
// - Results arrive at most one per conversion time
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none

module adc_window_comparator
    import window_cmp_pkg::*;
(
    input  wire logic                  hclk,      // System clock, 50 MHz
    input  wire logic                  hresetn,   // Asynchronous reset, active low
    input  wire logic                  hsel,      // Slave select
    input  wire logic [31:0]           haddr,     // Byte address
    input  wire logic [1:0]            htrans,    // Transfer type
    input  wire logic                  hwrite,    // Write when high
    input  wire logic [2:0]            hsize,     // Transfer size
    input  wire logic [31:0]           hwdata,    // Write data
    input  wire logic                  hready,    // Bus ready
    output logic      [31:0]           hrdata,    // Read data
    output logic                       hreadyout, // Slave ready
    output logic                       hresp,     // Always OKAY
    input  wire logic                  conv_done, // Conversion finished, one-cycle pulse
    input  wire logic [CODE_WIDTH-1:0] conv_code, // Raw 10-bit code from the SAR core
    output logic                       irq,       // Level interrupt
    output logic                       window_match_flag // Sticky window hit
);

    // ------------------------------------------------------------
    // Bus slave: address phase capture
    // ------------------------------------------------------------
    bus_req_t req;
    bus_req_t next_req;
    logic     addr_phase;

    // Only word accesses are legal; narrower ones are still answered OKAY
    assign addr_phase = hsel & hready & htrans[1];

    always_comb
    begin
        next_req       = req;
        next_req.valid = 1'b0;
        if (hready)
        begin
            next_req.valid = addr_phase;
            next_req.write = hwrite;
            next_req.addr  = haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req <= '0;
        end
        else
        begin
            req <= next_req;
        end
    end

    logic wr_en;
    logic [31:0] unused_hi;

    assign wr_en     = req.valid & req.write;
    assign unused_hi = {haddr[31:8], hsize, 5'h00} & 32'h00000000;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [1:0]            control;
    logic [1:0]            next_control;
    logic [STAT_WIDTH-1:0] mask;
    logic [STAT_WIDTH-1:0] next_mask;
    logic [7:0]            gt_high;
    logic [7:0]            next_gt_high;
    logic [7:0]            gt_low;
    logic [7:0]            next_gt_low;
    logic [7:0]            lt_high;
    logic [7:0]            next_lt_high;
    logic [7:0]            lt_low;
    logic [7:0]            next_lt_low;

    // Writes land in the data phase; byte registers keep the low lane
    always_comb
    begin
        next_control = control;
        next_mask    = mask;
        next_gt_high = gt_high;
        next_gt_low  = gt_low;
        next_lt_high = lt_high;
        next_lt_low  = lt_low;
        if (wr_en)
        begin
            unique case (req.addr)
                ADDR_CONTROL: next_control = hwdata[1:0];
                ADDR_MASK:    next_mask    = hwdata[STAT_WIDTH-1:0];
                ADDR_GT_HIGH: next_gt_high = hwdata[7:0];
                ADDR_GT_LOW:  next_gt_low  = hwdata[7:0];
                ADDR_LT_HIGH: next_lt_high = hwdata[7:0];
                ADDR_LT_LOW:  next_lt_low  = hwdata[7:0];
                default:      next_control = control;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            control <= CONTROL_RESET;
            mask    <= MASK_RESET;
            gt_high <= GT_HIGH_RESET;
            gt_low  <= GT_LOW_RESET;
            lt_high <= LT_HIGH_RESET;
            lt_low  <= LT_LOW_RESET;
        end
        else
        begin
            control <= next_control;
            mask    <= next_mask;
            gt_high <= next_gt_high;
            gt_low  <= next_gt_low;
            lt_high <= next_lt_high;
            lt_low  <= next_lt_low;
        end
    end

    // Limits are used exactly as written; format agreement is up to software
    limits_t limits;
    logic    diff_mode;
    logic    left_just;

    assign limits         = {gt_high, gt_low, lt_high, lt_low};
    assign diff_mode      = control[CTRL_DIFF_BIT];
    assign left_just      = control[CTRL_LJUST_BIT];

    // ------------------------------------------------------------
    // Result word formatting
    // ------------------------------------------------------------
    logic [WORD_WIDTH-1:0] shaped;

    // Left-justified keeps the code on top, right-justified sign-extends in differential
    always_comb
    begin
        if (left_just)
        begin
            shaped = {conv_code, 6'h00};
        end
        else if (diff_mode)
        begin
            shaped = {{(WORD_WIDTH-CODE_WIDTH){conv_code[CODE_WIDTH-1]}}, conv_code};
        end
        else
        begin
            shaped = {6'h00, conv_code};
        end
    end

    // ------------------------------------------------------------
    // Conversion spacing guard
    // ------------------------------------------------------------
    logic [SPACE_WIDTH-1:0] space;
    logic [SPACE_WIDTH-1:0] next_space;
    logic                   accept;
    logic                   too_fast;

    // A result inside the minimum conversion time cannot be genuine and is dropped
    assign accept   = conv_done & (space == '0);
    assign too_fast = conv_done & (space != '0);

    always_comb
    begin
        next_space = space;
        if (accept)
        begin
            next_space = SPACE_LOAD;
        end
        else if (space != '0)
        begin
            next_space = space - SPACE_WIDTH'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            space <= '0;
        end
        else
        begin
            space <= next_space;
        end
    end

    // ------------------------------------------------------------
    // Evaluation sequencer
    // ------------------------------------------------------------
    eval_state_t           state;
    eval_state_t           next_state;
    logic [WORD_WIDTH-1:0] result;
    logic [WORD_WIDTH-1:0] next_result;
    logic                  eval_signed;
    logic                  next_eval_signed;

    // Capture one cycle, judge the next; mode is frozen with the result
    always_comb
    begin
        next_state       = state;
        next_result      = result;
        next_eval_signed = eval_signed;
        unique case (state)
            ST_IDLE:
            begin
                if (accept)
                begin
                    next_result      = shaped;
                    next_eval_signed = diff_mode;
                    next_state       = ST_EVAL;
                end
            end
            ST_EVAL:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state       <= ST_IDLE;
            result      <= '0;
            eval_signed <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            result      <= next_result;
            eval_signed <= next_eval_signed;
        end
    end

    // ------------------------------------------------------------
    // Window decision
    // ------------------------------------------------------------
    logic res_gt_greater;
    logic res_lt_less;
    logic less_gt_greater;
    logic hit;
    logic evaluating;

    word_compare u_cmp_greater
    (
        .a           (result),
        .b           (limits.greater),
        .signed_mode (eval_signed),
        .a_gt_b      (res_gt_greater),
        .a_lt_b      ()
    );

    word_compare u_cmp_less
    (
        .a           (result),
        .b           (limits.less),
        .signed_mode (eval_signed),
        .a_gt_b      (),
        .a_lt_b      (res_lt_less)
    );

    word_compare u_cmp_order
    (
        .a           (limits.less),
        .b           (limits.greater),
        .signed_mode (eval_signed),
        .a_gt_b      (less_gt_greater),
        .a_lt_b      ()
    );

    // Limit order alone picks inside or outside; all compares are strict
    always_comb
    begin
        if (less_gt_greater)
        begin
            hit = res_gt_greater & res_lt_less;
        end
        else
        begin
            hit = res_gt_greater | res_lt_less;
        end
    end

    assign evaluating = (state == ST_EVAL);

    // ------------------------------------------------------------
    // Status, mask and interrupt
    // ------------------------------------------------------------
    logic [STAT_WIDTH-1:0] status;
    logic [STAT_WIDTH-1:0] events;
    logic [STAT_WIDTH-1:0] clears;

    assign events[STAT_MATCH_BIT] = evaluating & hit;
    assign events[STAT_DONE_BIT]  = evaluating;
    assign events[STAT_RATE_BIT]  = too_fast;
    assign clears = (wr_en && req.addr == ADDR_STATUS) ? hwdata[STAT_WIDTH-1:0] : '0;

    for (genvar i = 0; i < STAT_WIDTH; i++)
    begin : g_status
        sticky_bit u_flag
        (
            .hclk    (hclk),
            .hresetn (hresetn),
            .set     (events[i]),
            .clear   (clears[i]),
            .q       (status[i])
        );
    end

    logic next_irq;
    logic next_match_out;

    // Registered copies so every output comes from a flip-flop
    always_comb
    begin
        next_irq       = |(status & mask);
        next_match_out = status[STAT_MATCH_BIT];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq               <= 1'b0;
            window_match_flag <= 1'b0;
        end
        else
        begin
            irq               <= next_irq;
            window_match_flag <= next_match_out;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] next_hrdata;

    // Read data is sampled at the address edge; unmapped reads return zero
    always_comb
    begin
        next_hrdata = unused_hi;
        if (addr_phase && !hwrite)
        begin
            unique case (haddr[7:0])
                ADDR_CONTROL:   next_hrdata = {30'h00000000, control};
                ADDR_STATUS:    next_hrdata = {29'h00000000, status};
                ADDR_MASK:      next_hrdata = {29'h00000000, mask};
                ADDR_GT_HIGH:   next_hrdata = {24'h000000, gt_high};
                ADDR_GT_LOW:    next_hrdata = {24'h000000, gt_low};
                ADDR_LT_HIGH:   next_hrdata = {24'h000000, lt_high};
                ADDR_LT_LOW:    next_hrdata = {24'h000000, lt_low};
                ADDR_RESULT_HI: next_hrdata = {24'h000000, result[15:8]};
                ADDR_RESULT_LO: next_hrdata = {24'h000000, result[7:0]};
                default:        next_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;   // Zero wait states, always
            hresp     <= 1'b0;   // OKAY only
        end
    end

endmodule : adc_window_comparator

`default_nettype wire

// *** logic/window_cmp_pkg.sv ***
package window_cmp_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the AHB-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_MASK       = 8'h08;
    localparam logic [7:0] ADDR_GT_HIGH    = 8'h0C;
    localparam logic [7:0] ADDR_GT_LOW     = 8'h10;
    localparam logic [7:0] ADDR_LT_HIGH    = 8'h14;
    localparam logic [7:0] ADDR_LT_LOW     = 8'h18;
    localparam logic [7:0] ADDR_RESULT_HI  = 8'h1C;
    localparam logic [7:0] ADDR_RESULT_LO  = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_DIFF_BIT    = 0;
    localparam int CTRL_LJUST_BIT   = 1;
    localparam int STAT_MATCH_BIT   = 0;
    localparam int STAT_DONE_BIT    = 1;
    localparam int STAT_RATE_BIT    = 2;
    localparam int STAT_WIDTH       = 3;
    localparam int CODE_WIDTH       = 10;
    localparam int WORD_WIDTH       = 16;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [1:0]            CONTROL_RESET = 2'h0;
    localparam logic [STAT_WIDTH-1:0] MASK_RESET    = 3'h0;
    localparam logic [7:0]            GT_HIGH_RESET = 8'hFF;
    localparam logic [7:0]            GT_LOW_RESET  = 8'hFF;
    localparam logic [7:0]            LT_HIGH_RESET = 8'h00;
    localparam logic [7:0]            LT_LOW_RESET  = 8'h00;

    // ------------------------------------------------------------
    // Timing: fastest legal arrival of new results
    // ------------------------------------------------------------
    localparam int HCLK_PERIOD_NS   = 20;
    localparam int SAR_CLK_MAX_KHZ  = 3000;
    localparam int CONV_SAR_CLOCKS  = 10;
    localparam int MIN_CONV_NS      = (CONV_SAR_CLOCKS * 1000000 + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
    localparam int MIN_CONV_CYCLES  = (MIN_CONV_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
    localparam int SPACE_WIDTH      = 8;
    localparam logic [SPACE_WIDTH-1:0] SPACE_LOAD = SPACE_WIDTH'(MIN_CONV_CYCLES - 1);

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_req_t;

    typedef struct packed {
        logic [WORD_WIDTH-1:0] greater;
        logic [WORD_WIDTH-1:0] less;
    } limits_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EVAL = 2'b10
    } eval_state_t;

endpackage : window_cmp_pkg

// *** logic/word_compare.sv ***
`timescale 1ns/1ns
`default_nettype none

module word_compare
    import window_cmp_pkg::*;
(
    input  wire logic [WORD_WIDTH-1:0] a,           // Left operand
    input  wire logic [WORD_WIDTH-1:0] b,           // Right operand
    input  wire logic                  signed_mode, // Two's complement when high
    output logic                       a_gt_b,      // a strictly above b
    output logic                       a_lt_b       // a strictly below b
);

    // Flipping both sign bits turns a signed compare into an unsigned one
    logic [WORD_WIDTH-1:0] a_adj;
    logic [WORD_WIDTH-1:0] b_adj;

    always_comb
    begin
        a_adj = a;
        b_adj = b;
        if (signed_mode)
        begin
            a_adj[WORD_WIDTH-1] = ~a[WORD_WIDTH-1];
            b_adj[WORD_WIDTH-1] = ~b[WORD_WIDTH-1];
        end
        a_gt_b = a_adj > b_adj;
        a_lt_b = a_adj < b_adj;
    end

endmodule : word_compare

`default_nettype wire

// *** logic/sticky_bit.sv ***
`timescale 1ns/1ns
`default_nettype none

module sticky_bit
(
    input  wire logic hclk,    // System clock
    input  wire logic hresetn, // Asynchronous reset, active low
    input  wire logic set,     // Event pulse
    input  wire logic clear,   // Write-one-to-clear strobe
    output logic      q        // Sticky flag
);

    logic next_q;

    // Set beats clear so an event in the clearing cycle is kept
    always_comb
    begin
        next_q = q;
        if (clear)
        begin
            next_q = 1'b0;
        end
        if (set)
        begin
            next_q = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= 1'b0;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule : sticky_bit

`default_nettype wire

// *** tb/window_cmp_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none

module window_cmp_assertions
    import window_cmp_pkg::*;
(
    input wire logic        hclk,             // System clock
    input wire logic        hresetn,          // Reset, active low
    input wire logic        hsel,             // Slave select
    input wire logic [31:0] haddr,            // Byte address
    input wire logic [1:0]  htrans,           // Transfer type
    input wire logic        hwrite,           // Write when high
    input wire logic [31:0] hwdata,           // Write data
    input wire logic        hready,           // Bus ready
    input wire logic [31:0] hrdata,           // Read data
    input wire logic        hreadyout,        // Slave ready
    input wire logic        hresp,            // Response
    input wire logic        conv_done,        // Result strobe
    input wire logic        irq,              // Interrupt
    input wire logic        window_match_flag // Sticky hit
);
    // ----------------------------------------
    // Bus decode helpers
    // ----------------------------------------
    logic rd_take;
    logic wr_take;
    logic wr_data;
    logic st_data;

    assign rd_take = hsel & hready & htrans[1] & ~hwrite;
    assign wr_take = hsel & hready & htrans[1] & hwrite;

    logic clr_match;
    logic rd_status;

    // Status write that clears the match bit, and a status read
    assign clr_match = st_data & hwdata[STAT_MATCH_BIT];
    assign rd_status = rd_take & (haddr[7:0] == ADDR_STATUS);

    // Remember a write so its data phase can be tied to later effects
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_data <= 1'b0;
            st_data <= 1'b0;
        end
        else
        begin
            wr_data <= wr_take;
            st_data <= wr_take && haddr[7:0] == ADDR_STATUS;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("slave inserted a wait state");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("slave gave a non-OKAY response");
    property p_flag_rise; $rose(window_match_flag) |-> $past(conv_done, 3); endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("match flag rose without a result");
    property p_flag_fall; $fell(window_match_flag) |-> $past(clr_match, 2); endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("match flag fell without a clear");
    property p_irq_rise; $rose(irq) |-> $past(conv_done, 3) || $past(wr_data, 2); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
    property p_irq_fall; $fell(irq) |-> $past(wr_data, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
    property p_rd_idle; !$past(rd_take) |-> hrdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
    property p_poll; $past(rd_status) |-> hrdata[0] == window_match_flag; endproperty
    a_poll: assert property (p_poll) else $error("polled bit disagrees with flag");
endmodule : window_cmp_assertions

bind adc_window_comparator window_cmp_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .conv_done, .irq, .window_match_flag);

`default_nettype wire

// *** tb/adc_core_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module adc_core_model
    import window_cmp_pkg::*;
(
    input  wire logic                  hclk,      // System clock
    output logic                       conv_done, // Result strobe
    output logic [CODE_WIDTH-1:0]      conv_code  // Result code
);
    // ----------------------------------------
    // Conversion core stand-in
    // ----------------------------------------
    int since = 1000;

    initial
    begin
        conv_done = 1'b0;
        conv_code = '0;
    end

    // Cycles since the last strobe, for honest pacing
    always @(posedge hclk) since <= conv_done ? 0 : since + 1;

    // One result; fast skips the pacing so a refusal can be provoked
    task convert(input logic [CODE_WIDTH-1:0] code, input bit fast);
        @(posedge hclk); // Fresh edge, so back-to-back calls never drive the strobe twice at once
        while (!fast && since < MIN_CONV_CYCLES + 2) @(posedge hclk);
        conv_done <= 1'b1;
        conv_code <= code;
        @(posedge hclk);
        conv_done <= 1'b0;
        conv_code <= ~code; // Code is not held once the strobe ends
    endtask : convert
endmodule : adc_core_model

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

module testbench
    import window_cmp_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rq;
    logic hreadyout;
    logic hresp;
    logic conv_done;
    logic [CODE_WIDTH-1:0] conv_code;
    logic irq;
    logic window_match_flag;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    adc_window_comparator dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .conv_done, .conv_code, .irq, .window_match_flag);
    adc_core_model adc_u (.hclk, .conv_done, .conv_code);

    // ----------------------------------------
    // Clock, hang guard and shared tasks
    // ----------------------------------------
    always #10 hclk = ~hclk;

    // Whole run is well under this; a hang ends as a failure
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            close_out();
        end
    end

    task close_out;
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Single AHB-Lite transfer; waits on hready, no fixed latency assumed
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rq = hrdata;
    endtask : bus

    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rq, e);
    endtask : rdc

    task s_reset;
        rdc(ADDR_CONTROL, 32'h0);
        rdc(ADDR_GT_HIGH, 32'hFF);
        rdc(ADDR_GT_LOW, 32'hFF);
        rdc(ADDR_LT_HIGH, 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        bus(1'b1, ADDR_LT_LOW, 32'hA5);
        rdc(ADDR_LT_LOW, 32'hA5);
        bus(1'b1, 8'h3C, 32'hFFFFFFFF);
        rdc(8'h3C, 32'h0);
    endtask : s_reset

    // One conversion against one limit setting, judged on flag and registers
    task s_case(input logic [1:0] ctrl, input logic [15:0] gt, input logic [15:0] lt,
                input logic [9:0] code, input logic hit);
        logic [15:0] word;
        word = ctrl[1] ? {code, 6'h0} : ctrl[0] ? {{6{code[9]}}, code} : {6'h0, code};
        bus(1'b1, ADDR_CONTROL, {30'h0, ctrl});
        bus(1'b1, ADDR_GT_HIGH, {24'h0, gt[15:8]});
        bus(1'b1, ADDR_GT_LOW, {24'h0, gt[7:0]});
        bus(1'b1, ADDR_LT_HIGH, {24'h0, lt[15:8]});
        bus(1'b1, ADDR_LT_LOW, {24'h0, lt[7:0]});
        bus(1'b1, ADDR_STATUS, 32'h7);
        adc_u.convert(code, 1'b0);
        repeat (4) @(posedge hclk);
        chk({31'h0, window_match_flag}, {31'h0, hit});
        rdc(ADDR_STATUS, {30'h1, hit});
        rdc(ADDR_RESULT_HI, {24'h0, word[15:8]});
        rdc(ADDR_RESULT_LO, {24'h0, word[7:0]});
    endtask : s_case

    task s_irq;
        bus(1'b1, ADDR_MASK, 32'h1);
        s_case(2'h0, 16'h0040, 16'h0080, 10'h041, 1'b1);
        chk({31'h0, irq}, 32'h1);
        adc_u.convert(10'h040, 1'b0);
        repeat (4) @(posedge hclk);
        rdc(ADDR_STATUS, 32'h3);
        bus(1'b1, ADDR_MASK, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, ADDR_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, ADDR_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk({30'h0, irq, window_match_flag}, 32'h0);
        rdc(ADDR_STATUS, 32'h2);
    endtask : s_irq

    task s_rate;
        bus(1'b1, ADDR_STATUS, 32'h7);
        adc_u.convert(10'h100, 1'b0);
        adc_u.convert(10'h101, 1'b1);
        repeat (4) @(posedge hclk);
        rdc(ADDR_STATUS, 32'h6);
        rdc(ADDR_RESULT_LO, 32'h0);
    endtask : s_rate

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_case(2'h0, 16'h0040, 16'h0080, 10'h041, 1'b1);
        s_case(2'h0, 16'h0040, 16'h0080, 10'h040, 1'b0);
        s_case(2'h0, 16'h0040, 16'h0080, 10'h080, 1'b0);
        s_case(2'h0, 16'h0040, 16'h0080, 10'h07F, 1'b1);
        s_case(2'h0, 16'h0080, 16'h0040, 10'h03F, 1'b1);
        s_case(2'h0, 16'h0080, 16'h0040, 10'h040, 1'b0);
        s_case(2'h0, 16'h0080, 16'h0040, 10'h080, 1'b0);
        s_case(2'h0, 16'h0080, 16'h0040, 10'h3FF, 1'b1);
        s_case(2'h1, 16'hFFFF, 16'h0040, 10'h000, 1'b1);
        s_case(2'h1, 16'hFFFF, 16'h0040, 10'h3FF, 1'b0);
        s_case(2'h1, 16'hFFFF, 16'h0040, 10'h040, 1'b0);
        s_case(2'h1, 16'hFFFF, 16'h0040, 10'h200, 1'b0);
        s_case(2'h1, 16'h0040, 16'hFFFF, 10'h3FE, 1'b1);
        s_case(2'h1, 16'h0040, 16'hFFFF, 10'h3FF, 1'b0);
        s_case(2'h1, 16'h0040, 16'hFFFF, 10'h041, 1'b1);
        s_case(2'h1, 16'h0040, 16'hFFFF, 10'h000, 1'b0);
        s_case(2'h2, 16'h1000, 16'h2000, 10'h041, 1'b1);
        s_case(2'h2, 16'h1000, 16'h2000, 10'h040, 1'b0);
        s_case(2'h3, 16'hFFC0, 16'h1000, 10'h000, 1'b1);
        s_case(2'h3, 16'hFFC0, 16'h1000, 10'h3FF, 1'b0);
        s_case(2'h3, 16'hFFC0, 16'h1000, 10'h200, 1'b0);
        s_irq();
        s_rate();
        close_out();
    end
endmodule : testbench

`default_nettype wire
